/* design/sfwph_protect.v */
/*
 * Write-protect and pause logic of a serial flash: write-enable latch,
 * protect-level decode, hardware protection, clock count check, pause
 * control and fast-program detection.
 * Assumes a command decoder on the same clock presents the kind, address and
 * register bytes of the current command while chip select is low, and an
 * array engine that reports busy and completion.
 */
`timescale 1ns/1ps
`include "sfwph_regs.vh"
module sfwph_protect (
   input  wire        clock,
   input  wire        rst_b,
   input  wire        chipSelect_b,
   input  wire        serialClock,
   input  wire        serialIn,
   input  wire        protectFastprogPin_b,
   input  wire        pausePin_b,
   input  wire        highProgramVoltage,
   input  wire [3:0]  cmdKind,
   input  wire [21:0] cmdAddr,
   input  wire [7:0]  newStatus,
   input  wire [7:0]  newConfig,
   input  wire        soWanted,
   input  wire        opBusy,
   input  wire        opDone,
   output reg         opStart,
   output reg  [3:0]  opKind,
   output reg  [21:0] opAddr,
   output reg         opRejected,
   output wire        fastProgram,
   output reg         shiftStrobe,
   output reg         serialData,
   output reg         interfaceReset,
   output wire        soEnable_b,
   output wire        dataLine2,
   output wire        dataLine3,
   output reg         writeEnableLatch,
   output wire [7:0]  statusReg,
   output reg  [7:0]  configReg,
   output wire        softwareProtectState,
   output wire        hardwareProtectState,
   output wire        paused
);
   localparam [2:0] ST_IDLE   = 3'b001;
   localparam [2:0] ST_ACTIVE = 3'b010;
   localparam [2:0] ST_PAUSE  = 3'b100;

   wire [5:0] pinSync;
   wire       csB;
   wire       sck;
   wire       siS;
   wire       wpB;
   wire       holdB;
   wire       highVolt;
   reg        sckPrev;
   reg        holdPrev;
   reg  [2:0] state;
   reg  [2:0] next_state;
   reg  [2:0] clockCount;
   reg        anyClock;
   reg        enterPending;
   reg        exitPending;
   reg  [2:0] protectLevel;
   reg        statusLockBit;
   wire       sckRise;
   wire       sckFall;
   wire       holdFall;
   wire       holdRise;
   wire       csRise;
   wire       quadMode;
   wire       protectOriginBit;
   wire       countOk;
   wire       isModify;
   wire       isArrayOp;
   wire       inRange;
   wire [5:0] sector;
   wire [6:0] span;

   // All pins cross into the clock domain through the agreement filter.
   sfwph_sync #(.WIDTH(6)) pinSyncer (
      .clock      (clock),
      .rst_b      (rst_b),
      .async      ({highProgramVoltage, pausePin_b, protectFastprogPin_b, serialIn, serialClock, chipSelect_b}),
      .resetValue (6'h19),                                 // Idle: select, protect and pause high.
      .sync       (pinSync)
   );
   assign csB   = pinSync[0];
   assign sck   = pinSync[1];
   assign siS   = pinSync[2];
   assign wpB   = pinSync[3];
   assign holdB = pinSync[4];
   assign highVolt = pinSync[5];

   // Edge detection on the filtered pins.
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sckPrev  <= 1'b0;
         holdPrev <= 1'b1;
      end else begin
         sckPrev  <= sck;
         holdPrev <= holdB;
      end
   end
   assign sckRise  = sck & ~sckPrev;
   assign sckFall  = ~sck & sckPrev;
   assign holdFall = ~holdB & holdPrev;
   assign holdRise = holdB & ~holdPrev;
   assign csRise   = csB & (state != ST_IDLE);

   assign quadMode         = configReg[`SFWPH_CF_QUAD];
   assign protectOriginBit = configReg[`SFWPH_CF_ORIGIN];

   // Pause state machine; the pause role is dropped in quad pin mode.
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (!csB) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (csB) begin
               next_state = ST_IDLE;
            end else if (!quadMode && ((holdFall && !sck) || (enterPending && sckFall))) begin
               next_state = ST_PAUSE;
            end
         end
         ST_PAUSE: begin
            if (csB) begin
               next_state = ST_IDLE;
            end else if (quadMode || (holdRise && !sck) || (exitPending && sckFall)) begin
               next_state = ST_ACTIVE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Pending flags cover pause pin edges seen while the clock is high.
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state        <= ST_IDLE;
         enterPending <= 1'b0;
         exitPending  <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state != ST_ACTIVE || holdRise) begin
            enterPending <= 1'b0;
         end else if (holdFall && sck) begin
            enterPending <= 1'b1;
         end
         if (next_state != ST_PAUSE || holdFall) begin
            exitPending <= 1'b0;
         end else if (holdRise && sck) begin
            exitPending <= 1'b1;
         end
      end
   end
   assign paused = (state == ST_PAUSE);

   // Clock pulses are counted only while selected and not paused.
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         clockCount     <= 3'h0;
         anyClock       <= 1'b0;
         shiftStrobe    <= 1'b0;
         serialData     <= 1'b0;
         interfaceReset <= 1'b0;
      end else begin
         shiftStrobe    <= (state == ST_ACTIVE) && !csB && sckRise;
         serialData     <= (state == ST_ACTIVE) ? siS : serialData;
         interfaceReset <= csRise && paused;
         if (csB) begin
            clockCount <= 3'h0;
            anyClock   <= 1'b0;
         end else if (state == ST_ACTIVE && sckRise) begin
            clockCount <= clockCount + 3'h1;
            anyClock   <= 1'b1;
         end
      end
   end
   assign countOk = anyClock && ((clockCount & `SFWPH_BITS_MASK) == 3'h0);

   // Protected region decode: a span of sectors at the top or the bottom.
   assign sector = cmdAddr[`SFWPH_SECT_HI:`SFWPH_SECT_LO];
   assign span   = (protectLevel == 3'h0) ? 7'h00 :
                   (protectLevel == `SFWPH_LEVEL_ALL) ? 7'h40 :
                   (7'h01 << (protectLevel - 3'h1));
   assign inRange = protectOriginBit ? ({1'b0, sector} < span) :
                    ({1'b0, sector} >= (7'h40 - span));

   assign isModify  = (cmdKind >= `SFWPH_CMD_PAGE_PROG) && (cmdKind <= `SFWPH_CMD_OTP_PROG);
   assign isArrayOp = isModify && (cmdKind != `SFWPH_CMD_REG_WRITE) && (cmdKind != `SFWPH_CMD_OTP_PROG);

   assign softwareProtectState = (protectLevel != 3'h0);
   assign hardwareProtectState = statusLockBit && !wpB && !quadMode;

   // Commands are judged at chip select rise, never while a pause is broken off.
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         writeEnableLatch <= 1'b0;
         protectLevel     <= `SFWPH_LEVEL_RST;
         statusLockBit    <= `SFWPH_LOCK_RST;
         configReg        <= `SFWPH_CONFIG_RST;
         opStart          <= 1'b0;
         opKind           <= `SFWPH_CMD_NONE;
         opAddr           <= 22'h000000;
         opRejected       <= 1'b0;
      end else begin
         opStart    <= 1'b0;
         opRejected <= 1'b0;
         if (csRise && !paused && !opBusy) begin
            if (cmdKind == `SFWPH_CMD_WR_ENABLE && countOk) begin
               writeEnableLatch <= 1'b1;
            end else if (cmdKind == `SFWPH_CMD_WR_DISABLE && countOk) begin
               writeEnableLatch <= 1'b0;
            end else if (isModify) begin
               if (!writeEnableLatch || !countOk) begin
                  opRejected <= 1'b1;
               end else if (cmdKind == `SFWPH_CMD_REG_WRITE) begin
                  writeEnableLatch <= 1'b0;
                  if (!hardwareProtectState) begin
                     protectLevel  <= newStatus[`SFWPH_ST_LEVEL_HI:`SFWPH_ST_LEVEL_LO];
                     statusLockBit <= newStatus[`SFWPH_ST_LOCK];
                  end
                  configReg <= newConfig | (configReg & (8'h01 << `SFWPH_CF_ORIGIN));
               end else if (isArrayOp && (inRange || (cmdKind == `SFWPH_CMD_BULK_ERASE
                            && softwareProtectState))) begin
                  opRejected <= 1'b1;
               end else begin
                  opStart <= 1'b1;
                  opKind  <= cmdKind;
                  opAddr  <= cmdAddr;
               end
            end
         end
         if (opDone) begin
            writeEnableLatch <= 1'b0;
         end
      end
   end

   // Busy is reported straight from the array engine, which pausing never stops.
   assign statusReg = {statusLockBit, 2'h0, protectLevel, writeEnableLatch, opBusy};

   // Output floats while paused or deselected; low enable means driving.
   assign soEnable_b = paused || csB || !soWanted;

   // In quad pin mode the control pins become plain data lines.
   assign dataLine2 = quadMode ? wpB : 1'b0;
   assign dataLine3 = quadMode ? holdB : 1'b0;

   // High voltage shortens programming only outside quad pin mode.
   assign fastProgram = highVolt && !quadMode && (opKind == `SFWPH_CMD_PAGE_PROG
                        || opKind == `SFWPH_CMD_QUAD_PROG || opKind == `SFWPH_CMD_OTP_PROG);
endmodule // sfwph_protect

/* design/sfwph_regs.vh */
/*
 * Constants of the serial flash write-protect and pause block: command kinds,
 * status and configuration bit positions, reset values and array geometry.
 * Assumes it is included by bare name from design files of this block and from its bench.
 */
//Function
//- Latch clears at reset and on completion of every modifying command or write-disable.
//- The protected region rejects program and erase but still allows reads.
//- Origin zero: levels protect nothing, top 1..32 sectors, then all.
//- Origin one: levels protect nothing, bottom 1..32 sectors, then all.
//- Hardware protection depends jointly on protect pin level and status-lock bit.
//- Lock bit set with protect pin low freezes lock and level bits.
//- Modifying commands execute only if clock count is a multiple of eight.
//- Pause halts serial traffic but not an operation already in progress.
//- Pause starts on pause pin fall with clock low, else next clock fall.
//- Pause ends on pause pin rise with clock low, else next clock fall.
//- While paused the output floats and serial input and clock are ignored.
//- Chip select rising during pause resets the interface and drops the command.
//- Quad pin mode disables the pause function.
//- Quad pin mode turns protect pin into data line 2, pause into line 3.
//- High voltage on protect pin shortens programming; removal restores normal timing.
//- Quad pin mode disables the fast-program function.
//- Origin bit is configuration bit 5; zero top, one bottom; sticky once set.
`ifndef SFWPH_REGS_VH
`define SFWPH_REGS_VH

// Command kinds delivered by the command decoder.
`define SFWPH_CMD_NONE        4'h0
`define SFWPH_CMD_WR_ENABLE   4'h1
`define SFWPH_CMD_WR_DISABLE  4'h2
`define SFWPH_CMD_PAGE_PROG   4'h3
`define SFWPH_CMD_QUAD_PROG   4'h4
`define SFWPH_CMD_SECT_ERASE  4'h5
`define SFWPH_CMD_BULK_ERASE  4'h6
`define SFWPH_CMD_SMALL_ERASE 4'h7
`define SFWPH_CMD_LARGE_ERASE 4'h8
`define SFWPH_CMD_REG_WRITE   4'h9
`define SFWPH_CMD_OTP_PROG    4'ha

// Status byte layout.
`define SFWPH_ST_BUSY         0
`define SFWPH_ST_LATCH        1
`define SFWPH_ST_LEVEL_LO     2
`define SFWPH_ST_LEVEL_HI     4
`define SFWPH_ST_LOCK         7

// Configuration byte layout.
`define SFWPH_CF_QUAD         1
`define SFWPH_CF_ORIGIN       5

// Reset values.
`define SFWPH_LEVEL_RST       3'h0
`define SFWPH_LOCK_RST        1'h0
`define SFWPH_CONFIG_RST      8'h00

// Geometry: 64 sectors of 64 KB in a 22-bit address space.
`define SFWPH_SECT_HI         21
`define SFWPH_SECT_LO         16
`define SFWPH_LEVEL_ALL       3'h7
`define SFWPH_BITS_MASK       3'h7

`endif

/* design/sfwph_sync.v */
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to clock; output changes only when
 * stages two and three agree.
 */
`timescale 1ns/1ps
module sfwph_sync #(
   parameter WIDTH = 1
) (
   input  wire             clock,
   input  wire             rst_b,
   input  wire [WIDTH-1:0] async,
   input  wire [WIDTH-1:0] resetValue,
   output reg  [WIDTH-1:0] sync
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   reg [WIDTH-1:0] filtered;
   reg [1:0]       fill;

   // Stage one feeds stage two only; the fill count tells when stage three holds a real sample.
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         fill   <= 2'h0;
      end else begin
         stage1 <= async;
         stage2 <= stage1;
         stage3 <= stage2;
         if (fill != 2'h3) begin
            fill <= fill + 2'h1;
         end
      end
   end

   // Each bit follows stage three once two and three agree on it, and holds otherwise.
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         filtered <= {WIDTH{1'b0}};
      end else if (fill != 2'h3) begin
         filtered <= resetValue;
      end else begin
         filtered <= (stage3 & ~(stage2 ^ stage3)) | (filtered & (stage2 ^ stage3));
      end
   end

   // Reset and the fill time show the idle levels, so no false pin edge follows reset.
   always @* begin
      sync = (fill == 2'h3) ? filtered : resetValue;
   end
endmodule // sfwph_sync

/* sim/sfwph_checker.sv */
/* Assertion checker for the write-protect and pause block.
   Assumes it is bound to sfwph_protect and sees only its ports. */
`timescale 1ns/1ps
module sfwph_checker (
   input wire       clock,
   input wire       rst_b,
   input wire       opDone,
   input wire       opStart,
   input wire       opRejected,
   input wire       shiftStrobe,
   input wire       interfaceReset,
   input wire       soEnable_b,
   input wire       fastProgram,
   input wire       writeEnableLatch,
   input wire [7:0] statusReg,
   input wire [7:0] configReg,
   input wire       softwareProtectState,
   input wire       hardwareProtectState,
   input wire       paused
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // Quad mode held over two cycles.
   sequence quadHeld;
      configReg[1] ##1 configReg[1];
   endsequence
   start_needs_wel_a: assert property (opStart |-> writeEnableLatch && !opRejected)
      else $error("start without latch");
   done_clears_a: assert property (opDone |=> !writeEnableLatch)
      else $error("latch kept after done");
   reject_keeps_a: assert property (opRejected |-> $stable(writeEnableLatch))
      else $error("reject moved latch");
   soft_state_a: assert property (softwareProtectState == (statusReg[4:2] != 3'h0))
      else $error("soft state wrong");
   hw_state_a: assert property (hardwareProtectState |-> statusReg[7] && !configReg[1])
      else $error("hard state wrong");
   lock_freeze_a: assert property (hardwareProtectState |=> $stable(statusReg[7:2]))
      else $error("locked bits moved");
   origin_sticky_a: assert property (configReg[5] |=> configReg[5])
      else $error("origin cleared");
   pause_float_a: assert property (paused |-> soEnable_b && !shiftStrobe)
      else $error("active while paused");
   pause_reset_a: assert property (interfaceReset |-> $past(paused))
      else $error("reset without pause");
   quad_no_pause_a: assert property (quadHeld |-> !paused)
      else $error("paused in quad");
   fast_quad_a: assert property (fastProgram |-> !configReg[1])
      else $error("fast in quad");
endmodule // sfwph_checker
bind sfwph_protect sfwph_checker chk (
   .clock(clock), .rst_b(rst_b), .opDone(opDone), .opStart(opStart), .opRejected(opRejected),
   .shiftStrobe(shiftStrobe), .interfaceReset(interfaceReset), .soEnable_b(soEnable_b),
   .fastProgram(fastProgram), .writeEnableLatch(writeEnableLatch), .statusReg(statusReg),
   .configReg(configReg), .softwareProtectState(softwareProtectState),
   .hardwareProtectState(hardwareProtectState), .paused(paused)
);

/* sim/sfwph_host.sv */
/* Host model driving chip select, serial clock, data and pause pins.
   Assumes a 4 ns system clock; the serial clock idles low between frames. */
`timescale 1ns/1ps
module sfwph_host (
   input  wire clock,
   output reg  chipSelect_b,
   output reg  serialClock,
   output reg  serialIn,
   output reg  pausePin_b
);
   // Pins start deselected, clock low and pause released.
   initial begin
      chipSelect_b = 1'b1;
      serialClock = 1'b0;
      serialIn = 1'b0;
      pausePin_b = 1'b1;
   end
   // Waits whole clocks so pins only move at falling edges.
   task wt(input integer n);
      repeat (n) @(negedge clock);
   endtask
   // Pause is already high before selecting, so no pause is re-entered.
   task open;
      chipSelect_b = 1'b0;
      wt(8);
   endtask
   // Sends n serial clock pulses of 32 ns high time in a 64 ns period, with fresh data on each.
   task clk(input integer n);
      repeat (n) begin
         serialIn = ~serialIn;
         wt(8);
         serialClock = 1'b1;
         wt(8);
         serialClock = 1'b0;
      end
   endtask
   // Deselects, stops holding data and leaves time for the verdict.
   task close;
      chipSelect_b = 1'b1;
      serialIn = ~serialIn;
      wt(14);
   endtask
   task frame(input integer n);
      open;
      clk(n);
      close;
   endtask
endmodule // sfwph_host

/* sim/sfwph_protect_tb.sv */
/* Self-checking bench for the write-protect and pause block.
   Assumes the host model drives the pins and the bench plays decoder and engine. */
`timescale 1ns/1ps
`include "sfwph_regs.vh"
module sfwph_protect_tb;
   reg         clock, rst_b, soWanted, opBusy, opDone, protectFastprogPin_b, highProgramVoltage;
   reg  [3:0]  cmdKind;
   reg  [21:0] cmdAddr;
   reg  [7:0]  newStatus, newConfig;
   reg         sawStart, sawRej, sawReset, quadOn;
   wire        chipSelect_b, serialClock, serialIn, pausePin_b, opStart, opRejected, fastProgram;
   wire        shiftStrobe, interfaceReset, soEnable_b, dataLine2, dataLine3, writeEnableLatch;
   wire        softwareProtectState, hardwareProtectState, paused, serialData;
   wire [3:0]  opKind;
   wire [21:0] opAddr;
   wire [7:0]  statusReg, configReg;
   integer     failures, n_tests, cycles, nStrobe, k;
   sfwph_host host (.clock(clock), .chipSelect_b(chipSelect_b), .serialClock(serialClock),
      .serialIn(serialIn), .pausePin_b(pausePin_b));
   sfwph_protect dut (.clock(clock), .rst_b(rst_b), .chipSelect_b(chipSelect_b),
      .serialClock(serialClock), .serialIn(serialIn), .protectFastprogPin_b(protectFastprogPin_b),
      .pausePin_b(pausePin_b), .highProgramVoltage(highProgramVoltage), .cmdKind(cmdKind),
      .cmdAddr(cmdAddr), .newStatus(newStatus), .newConfig(newConfig), .soWanted(soWanted),
      .opBusy(opBusy), .opDone(opDone), .opStart(opStart), .opKind(opKind), .opAddr(opAddr),
      .opRejected(opRejected), .fastProgram(fastProgram), .shiftStrobe(shiftStrobe), .serialData(serialData),
      .interfaceReset(interfaceReset), .soEnable_b(soEnable_b), .dataLine2(dataLine2),
      .dataLine3(dataLine3), .writeEnableLatch(writeEnableLatch), .statusReg(statusReg),
      .configReg(configReg), .softwareProtectState(softwareProtectState),
      .hardwareProtectState(hardwareProtectState), .paused(paused));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Records pulses and cuts a hung run short.
   always @(posedge clock) begin
      cycles = cycles + 1;
      nStrobe = nStrobe + shiftStrobe;
      if (opStart) sawStart = 1'b1;
      if (opRejected) sawRej = 1'b1;
      if (interfaceReset) sawReset = 1'b1;
      if (cycles == 90000) begin
         failures = failures + 1;
         finish_test;
      end
   end
   task check(input [31:0] seen, input [31:0] want);
      n_tests = n_tests + 1;
      if (seen !== want) begin
         failures = failures + 1;
         $display("wrong value at %0t: saw %0h, want %0h", $time, seen, want);
      end
   endtask
   task finish_test;
      $display("failures %0d, checks %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Write enable precedes each modifying command sent by op and regw.
   task write_enable_cmd;
      cmdKind = `SFWPH_CMD_WR_ENABLE;
      host.frame(8);
      check(writeEnableLatch, 1);
   endtask
   // Sends one command and judges start, kind, fast mode and latch clearing.
   task op(input [3:0] kind, input [5:0] sect, input want);
      write_enable_cmd;
      cmdKind = kind;
      cmdAddr = {sect, sect, sect, sect[3:0]};
      sawStart = 1'b0;
      sawRej = 1'b0;
      host.frame(8);
      check(sawStart, want);
      check(sawRej, !want);
      if (sawStart) begin
         check(opKind, kind);
         check(opAddr, cmdAddr);
         if (kind == `SFWPH_CMD_PAGE_PROG) check(fastProgram, highProgramVoltage && !quadOn);
         opDone = 1'b1;
         host.wt(1);
         opDone = 1'b0;
         host.wt(1);
         check(writeEnableLatch, 0);
      end
   endtask
   task regw(input [7:0] st, input [7:0] cf);
      write_enable_cmd;
      cmdKind = `SFWPH_CMD_REG_WRITE;
      // Bits with no protect role are set too; status drops them, while config stores them.
      newStatus = st | 8'h63;
      newConfig = cf | 8'hdc;
      host.frame(8);
      check(writeEnableLatch, 0);
   endtask
   function prot(input o, input [2:0] l, input [5:0] s);
      integer n;
      n = (l == 3'h7) ? 64 : (l == 3'h0) ? 0 : (1 << (l - 1));
      prot = o ? (s < n) : (s >= 64 - n);
   endfunction
   // Every modifying kind but the register write runs, then fast programming follows the voltage.
   task t_kinds;
      for (k = 3; k < 11; k = k + 1)
         if (k != 9) op(k[3:0], 6'h05, 1'b1);
      highProgramVoltage = 1'b1;
      op(`SFWPH_CMD_PAGE_PROG, 6'h05, 1'b1);
      highProgramVoltage = 1'b0;
      host.wt(8);
      check(fastProgram, 0);
   endtask
   // Without the latch, and with a bad clock count, commands are dropped.
   task t_refuse;
      cmdKind = `SFWPH_CMD_PAGE_PROG;
      sawRej = 1'b0;
      host.frame(8);
      check(sawRej, 1);
      write_enable_cmd;
      cmdKind = `SFWPH_CMD_PAGE_PROG;
      sawRej = 1'b0;
      sawStart = 1'b0;
      host.frame(12);
      check({sawStart, sawRej, writeEnableLatch}, 3'b011);
      cmdKind = `SFWPH_CMD_WR_DISABLE;
      host.frame(8);
      check(writeEnableLatch, 0);
   endtask
   // A busy engine stays visible through a pause and holds off new commands.
   task t_busy;
      opBusy = 1'b1;
      cmdKind = `SFWPH_CMD_WR_ENABLE;
      host.frame(8);
      check({statusReg[0], writeEnableLatch}, 2'b10);
      host.open;
      host.pausePin_b = 1'b0;
      host.wt(10);
      check({paused, statusReg[0]}, 2'b11);
      host.pausePin_b = 1'b1;
      host.wt(10);
      host.close;
      opBusy = 1'b0;
   endtask
   // Each level is tried on the sectors on either side of its boundary.
   task t_levels(input o);
      integer l, n, j;
      reg [5:0] s;
      for (l = 0; l < 8; l = l + 1) begin
         n = (l == 7) ? 64 : (l == 0) ? 0 : (1 << (l - 1));
         regw({3'h0, l[2:0], 2'h0}, {2'h0, o, 5'h00});
         check(softwareProtectState, l != 0);
         for (j = 0; j < 2; j = j + 1) begin
            s = (o ? n - 1 : 63 - n) + j;
            op(`SFWPH_CMD_SECT_ERASE, s, !prot(o, l[2:0], s));
         end
         op(`SFWPH_CMD_BULK_ERASE, 6'h00, l == 0);
      end
   endtask
   // The lock bit with the pin low freezes lock and level bits.
   task t_lock;
      regw(8'h84, 8'h00);
      check(configReg[5], 1);
      protectFastprogPin_b = 1'b0;
      host.wt(8);
      check(hardwareProtectState, 1);
      regw(8'h00, 8'h20);
      check(statusReg[7:2], 6'h21);
      protectFastprogPin_b = 1'b1;
      regw(8'h00, 8'h20);
      check(statusReg[7:2], 6'h00);
   endtask
   // Clocks during a pause are ignored; chip select rising abandons the command.
   task t_pause;
      soWanted = 1'b1;
      cmdKind = `SFWPH_CMD_WR_ENABLE;
      host.open;
      host.clk(3);
      host.pausePin_b = 1'b0;
      host.wt(10);
      check({paused, soEnable_b}, 2'b11);
      nStrobe = 0;
      k = serialData;
      host.clk(1);
      check(serialData, k);
      host.clk(1);
      check(nStrobe, 0);
      host.pausePin_b = 1'b1;
      host.wt(10);
      check({paused, soEnable_b}, 2'b00);
      host.clk(5);
      check(serialData, host.serialIn);
      host.close;
      check(writeEnableLatch, 1);
      cmdKind = `SFWPH_CMD_WR_DISABLE;
      host.open;
      host.clk(7);
      host.wt(8);
      host.serialClock = 1'b1;
      host.pausePin_b = 1'b0;
      host.wt(10);
      check(paused, 0);
      host.serialClock = 1'b0;
      host.wt(10);
      check(paused, 1);
      sawReset = 1'b0;
      host.close;
      host.pausePin_b = 1'b1;
      host.wt(8);
      check({sawReset, writeEnableLatch}, 2'b11);
   endtask
   // Quad mode turns the pins into data lines and disables pause and fast mode.
   task t_quad;
      regw(8'h00, 8'h22);
      quadOn = 1'b1;
      host.open;
      host.pausePin_b = 1'b0;
      host.wt(10);
      check({paused, dataLine3, dataLine2}, 3'b001);
      host.pausePin_b = 1'b1;
      host.close;
      highProgramVoltage = 1'b1;
      op(`SFWPH_CMD_PAGE_PROG, 6'h10, 1'b1);
   endtask
   initial begin
      {rst_b, soWanted, opBusy, opDone, highProgramVoltage, sawStart, sawRej, sawReset, quadOn} = 9'h000;
      {cmdKind, cmdAddr, newStatus, newConfig} = 42'h0;
      protectFastprogPin_b = 1'b1;
      {failures, n_tests, cycles, nStrobe} = 128'h0;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      host.wt(6);
      check({writeEnableLatch, statusReg, configReg}, 17'h0);
      t_kinds;
      t_refuse;
      t_busy;
      t_levels(1'b0);
      t_levels(1'b1);
      t_lock;
      t_pause;
      t_quad;
      finish_test;
   end
endmodule // sfwph_protect_tb
